// *** bgc_monitor.sv ***
// concurrent checks on the broadcast and global control block
// assumes binding to broadcast_global_ctrl; clk domain only
`timescale 1ns/1ps
module bgc_monitor (
   input wire logic         clk,
   input wire logic         rstn,
   input wire logic         update_strobe,
   input wire logic [159:0] route_map,
   input wire logic [31:0]  out_enable_bits,
   input wire logic [159:0] route_sel,
   input wire logic [31:0]  out_drive,
   input wire logic         broadcast_on,
   input wire logic [4:0]   input_index,
   input wire logic         clamp_on,
   input wire logic         operational,
   input wire logic         global_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // sequences
   sequence strobe_quiet; !update_strobe [*6]; endsequence
   sequence map_steady; (!broadcast_on && $stable(route_map)) [*3]; endsequence
   // ==========================================================
   // properties
   a_drive_and: assert property (
      ($stable(out_enable_bits) && $stable(global_enable)) [*3]
      |-> out_drive == (out_enable_bits & {32{global_enable}})) else $error("out_drive wrong");
   a_route_bcast: assert property (
      broadcast_on && $past(broadcast_on) && $stable(input_index)
      |-> route_sel == {32{input_index}}) else $error("broadcast route wrong");
   a_route_keep: assert property (
      map_steady |-> route_sel == route_map) else $error("route_sel not route_map");
   a_map_restore: assert property (
      $fell(broadcast_on) |-> ##[0:2] route_sel == route_map) else $error("map not restored");
   a_reset_state: assert property (
      $rose(rstn) |-> !operational && !global_enable && !broadcast_on && out_drive == 0)
      else $error("reset state wrong");
   a_quiet_hold: assert property (
      strobe_quiet |-> $stable({clamp_on, operational, global_enable, broadcast_on, input_index}))
      else $error("state moved without strobe");
   a_strobe_cause: assert property (
      $changed({clamp_on, operational, global_enable, broadcast_on, input_index})
      |-> $past(update_strobe, 3)) else $error("state changed off strobe");
   a_drive_off: assert property (
      !global_enable && !$past(global_enable) |-> out_drive == 0) else $error("output driven");
endmodule : bgc_monitor
bind broadcast_global_ctrl bgc_monitor mon (.clk, .rstn, .update_strobe, .route_map,
   .out_enable_bits, .route_sel, .out_drive, .broadcast_on, .input_index, .clamp_on,
   .operational, .global_enable);

// *** broadcast_global_ctrl.sv ***
// broadcast and global control word interpreter for a 32x32 video switch
// assumes route_map and out_enable_bits come from logic on clk; the serial
// pins come from the host and are asynchronous to clk
// assumes the host keeps the shifted word and the shift clock still from the
// strobe rise until the strobe has been seen on clk (two to three cycles)
// assumes the strobe stays high, and then low, for at least three clk cycles
// assumes rstn is released with the strobe low and the shift clock still
// a decoded word reaches the outputs three to four clk cycles after the strobe
// clamp, power and global enable leave as plain levels for the analog side
//
// Contract
// - top bits 0,1,1 mark the broadcast command
// - broadcast bits 12..8 pick one input, routed to all 32 outputs
// - broadcast bit 0 turns broadcast on (1) or off (0)
// - per-output assignments are kept and return when broadcast ends
// - reset leaves outputs disabled and the device in standby
// - control bit 9 sets one clamp setting for all inputs
// - control bit 1: zero standby, one operational
// - control bit 0 is global output enable; zero forces all off
// - output driven only when own enable AND global enable are one
// - words are 16 bits, rising shift clock, bit 0 first
// - shifted word updates state only on update strobe rising edge
`timescale 1ns/1ps
module broadcast_global_ctrl (
   input  wire logic                                      clk,
   input  wire logic                                      rstn,
   input  wire logic                                      link_clk,
   input  wire logic                                      serial_in,
   input  wire logic                                      update_strobe,
   input  wire logic [xpt_ctrl_pkg::NUM_OUT*xpt_ctrl_pkg::IDX_W-1:0] route_map,
   input  wire logic [xpt_ctrl_pkg::NUM_OUT-1:0]          out_enable_bits,
   output logic [xpt_ctrl_pkg::NUM_OUT*xpt_ctrl_pkg::IDX_W-1:0] route_sel,
   output logic [xpt_ctrl_pkg::NUM_OUT-1:0]               out_drive,
   output logic                                           broadcast_on,
   output logic [xpt_ctrl_pkg::IDX_W-1:0]                 input_index,
   output logic                                           clamp_on,
   output logic                                           operational,
   output logic                                           global_enable
);
   import xpt_ctrl_pkg::*;

   // ==========================================================
   // link domain: serial shift register
   logic [WORD_W-1:0] shift_word;

   serial_shifter u_shifter (
      .link_clk   (link_clk),
      .rstn       (rstn),
      .serial_in  (serial_in),
      .shift_word (shift_word)
   );

   // ==========================================================
   // word crossing into clk: two flops per bit
   // the word is quasi-static around the strobe, so a bit caught while it
   // moves is replaced by its settled value one edge later; the strobe
   // crossing below takes the same two edges, so the decode never sees
   // a word that is still being shifted
   logic [WORD_W-1:0] word_meta;
   logic [WORD_W-1:0] word_sync;
   logic [WORD_W-1:0] next_word_meta;
   logic [WORD_W-1:0] next_word_sync;

   // meta feeds only the sync flop; decode reads only word_sync
   always_comb begin
      next_word_meta = shift_word;
      next_word_sync = word_meta;
   end

   // both stages clear with the rest of the block
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         word_meta <= RST_WORD;
         word_sync <= RST_WORD;
      end else begin
         word_meta <= next_word_meta;
         word_sync <= next_word_sync;
      end
   end

   // ==========================================================
   // strobe synchroniser and rising edge detect
   logic strobe_meta;
   logic strobe_sync;
   logic strobe_prev;
   logic next_strobe_meta;
   logic next_strobe_sync;
   logic next_strobe_prev;
   logic strobe_rise;

   // meta feeds only the sync flop; edge detect looks at sync and prev
   // prev resets low like the idle strobe pin, so reset gives no false edge
   // a strobe shorter than one clk cycle may be missed
   always_comb begin
      next_strobe_meta = update_strobe;
      next_strobe_sync = strobe_meta;
      next_strobe_prev = strobe_sync;
      strobe_rise      = strobe_sync & ~strobe_prev;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strobe_meta <= 1'b0;
         strobe_prev <= 1'b0;
         strobe_sync <= 1'b0;
      end else begin
         strobe_meta <= next_strobe_meta;
         strobe_sync <= next_strobe_sync;
         strobe_prev <= next_strobe_prev;
      end
   end

   // ==========================================================
   // word decode and global state
   // the word is read only through word_sync, which has settled on the
   // complete word by the time the synchronised strobe shows its rising edge
   // unused bits of the word are ignored; they change nothing here
   logic [2:0]       cmd;
   logic             bcast_state;
   logic [IDX_W-1:0] bcast_idx;
   logic             clamp_state;
   logic             oper_state;
   logic             gen_state;
   logic             next_bcast_state;
   logic [IDX_W-1:0] next_bcast_idx;
   logic             next_clamp_state;
   logic             next_oper_state;
   logic             next_gen_state;

   // apply broadcast or control fields on strobe rise; other commands ignored
   always_comb begin
      cmd              = word_sync[CMD_HI:CMD_LO];
      next_bcast_state = bcast_state;
      next_bcast_idx   = bcast_idx;
      next_clamp_state = clamp_state;
      next_oper_state  = oper_state;
      next_gen_state   = gen_state;
      if (strobe_rise) begin
         if (cmd == CMD_BROADCAST) begin
            next_bcast_state = word_sync[BCAST_EN_POS];
            next_bcast_idx   = word_sync[IDX_HI:IDX_LO];
         end else if (cmd == CMD_CONTROL) begin
            next_clamp_state = word_sync[CLAMP_POS];
            next_oper_state  = word_sync[POWER_POS];
            next_gen_state   = word_sync[GLOBAL_POS];
         end
      end
   end

   // reset: standby, outputs off, broadcast off
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bcast_state <= RST_BCAST_ON;
         bcast_idx   <= RST_IDX;
         clamp_state <= RST_CLAMP;
         oper_state  <= RST_OPER;
         gen_state   <= RST_GLOBAL_EN;
      end else begin
         bcast_state <= next_bcast_state;
         bcast_idx   <= next_bcast_idx;
         clamp_state <= next_clamp_state;
         oper_state  <= next_oper_state;
         gen_state   <= next_gen_state;
      end
   end

   // ==========================================================
   // per-output route select and drive enable
   logic [NUM_OUT*IDX_W-1:0] next_route_sel;
   logic [NUM_OUT-1:0]       next_out_drive;

   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_out
         // broadcast overrides but never overwrites the kept map
         // route_map and out_enable_bits reach the outputs one clk edge after they change
         // standby alone does not gate a drive; only the global enable does
         always_comb begin
            next_route_sel[g*IDX_W +: IDX_W] = bcast_state ? bcast_idx
                                              : route_map[g*IDX_W +: IDX_W];
            next_out_drive[g] = out_enable_bits[g] & gen_state;
         end
      end
   endgenerate

   // ==========================================================
   // output registers
   logic             next_broadcast_on;
   logic [IDX_W-1:0] next_input_index;
   logic             next_clamp_on;
   logic             next_operational;
   logic             next_global_enable;

   // status outputs mirror the held state
   // registered so every output of the block comes straight from a flop
   always_comb begin
      next_broadcast_on  = bcast_state;
      next_input_index   = bcast_idx;
      next_clamp_on      = clamp_state;
      next_operational   = oper_state;
      next_global_enable = gen_state;
   end

   // reset: outputs off and standby; route_sel follows route_map one edge later
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         route_sel     <= '0;
         out_drive     <= '0;
         broadcast_on  <= RST_BCAST_ON;
         input_index   <= RST_IDX;
         clamp_on      <= RST_CLAMP;
         operational   <= RST_OPER;
         global_enable <= RST_GLOBAL_EN;
      end else begin
         route_sel     <= next_route_sel;
         out_drive     <= next_out_drive;
         broadcast_on  <= next_broadcast_on;
         input_index   <= next_input_index;
         clamp_on      <= next_clamp_on;
         operational   <= next_operational;
         global_enable <= next_global_enable;
      end
   end
endmodule : broadcast_global_ctrl

// *** broadcast_global_ctrl_bench.sv ***
// self-checking bench for the broadcast and global control block
// assumes host_link as the far side and the bound checker
`timescale 1ns/1ps
module broadcast_global_ctrl_bench;
   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   logic         link_clk, serial_in, update_strobe, broadcast_on, clamp_on;
   logic         operational, global_enable;
   logic [159:0] route_map, route_sel;
   logic [31:0]  out_enable_bits, out_drive;
   logic [4:0]   input_index;
   int           errors = 0, checks_done = 0, cycles = 0;
   // word beside expected {broadcast, index, clamp, power, global}
   logic [24:0]  rows [10] = '{{16'hE003, 9'h003}, {16'h6501, 9'h12B}, {16'h7F01, 9'h1FB},
      {16'h6000, 9'h003}, {16'hE202, 9'h006}, {16'h2345, 9'h006}, {16'hE001, 9'h001},
      {16'h0000, 9'h001}, {16'hA203, 9'h001}, {16'hC203, 9'h001}};
   broadcast_global_ctrl DUT (.clk, .rstn, .link_clk, .serial_in, .update_strobe, .route_map,
      .out_enable_bits, .route_sel, .out_drive, .broadcast_on, .input_index, .clamp_on,
      .operational, .global_enable);
   host_link host (.link_clk, .serial_in, .update_strobe);
   // clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic check(input string name, input logic [159:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic check_all(input logic [8:0] e);
      check("broadcast_on", broadcast_on, e[8]);
      check("input_index", input_index, e[7:3]);
      check("clamp_on", clamp_on, e[2]);
      check("operational", operational, e[1]);
      check("global_enable", global_enable, e[0]);
      check("route_sel", route_sel, e[8] ? {32{e[7:3]}} : route_map);
      check("out_drive", out_drive, out_enable_bits & {32{e[0]}});
   endtask : check_all
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // main sequence: reset, table rows, then the awkward cases
   initial begin
      for (int n = 0; n < 32; n++) route_map[5*n +: 5] = 5'(n * 7);
      out_enable_bits = 32'hA5C3_0F96;
      repeat (8) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (3) @(posedge clk);
      #1 check_all(9'h000);
      $display("reset test done");
      foreach (rows[i]) begin
         host.send(rows[i][24:9]);
         repeat (8) @(posedge clk);
         #1 check_all(rows[i][8:0]);
         $display("row %0d done", i);
      end
      host.send(16'h6901);
      @(posedge clk) #1 route_map = ~route_map;
      repeat (8) @(posedge clk);
      #1 check_all(9'h149);
      host.send(16'h6900);
      repeat (8) @(posedge clk);
      #1 check_all(9'h049);
      $display("restore test done");
      rstn = 1'b0;
      #20 check("out_drive", out_drive, 0);
      check("operational", operational, 0);
      @(posedge clk) #1 rstn = 1'b1;
      host.send(16'hE003);
      repeat (8) @(posedge clk);
      #1 check_all(9'h003);
      $display("second reset test done");
      give_verdict();
   end
endmodule : broadcast_global_ctrl_bench

// *** host_link.sv ***
// host model driving the three-wire serial link
// assumes the link clock stands low between words
`timescale 1ns/1ps
module host_link (
   output logic link_clk,
   output logic serial_in,
   output logic update_strobe
);
   // idle levels
   initial begin
      link_clk = 1'b0;
      serial_in = 1'b1;
      update_strobe = 1'b0;
   end
   // shift one word lsb first at 160 ns, then pulse the strobe
   task automatic send(input logic [15:0] w);
      #3;
      for (int b = 0; b < 16; b++) begin
         serial_in = w[b];
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
      end
      serial_in = ~w[15]; // released line shows the inverse
      #40 update_strobe = 1'b1;
      #40 update_strobe = 1'b0;
      #40;
   endtask : send
endmodule : host_link

// *** serial_shifter.sv ***
// link-side 16-bit shift register clocked by the serial shift clock
// assumes the host holds the shift clock still while the update strobe is high
`timescale 1ns/1ps
module serial_shifter (
   input  wire logic                            link_clk,
   input  wire logic                            rstn,
   input  wire logic                            serial_in,
   output logic [xpt_ctrl_pkg::WORD_W-1:0]      shift_word
);
   import xpt_ctrl_pkg::*;

   logic [WORD_W-1:0] next_shift_word;

   // ==========================================================
   // shift: first bit ends in bit 0, last bit in bit 15
   always_comb begin
      next_shift_word = {serial_in, shift_word[WORD_W-1:1]};
   end

   // register on rising shift clock, free of the update strobe
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         shift_word <= RST_WORD;
      end else begin
         shift_word <= next_shift_word;
      end
   end
endmodule : serial_shifter

// *** xpt_ctrl_pkg.sv ***
// constants shared by the serial shifter and the broadcast/global control block
// assumes a 16-bit serial word and a 32x32 crosspoint
package xpt_ctrl_pkg;
   // ==========================================================
   // word layout
   localparam int unsigned WORD_W       = 16;
   localparam int unsigned CMD_HI       = 15;
   localparam int unsigned CMD_LO       = 13;
   localparam int unsigned IDX_HI       = 12;
   localparam int unsigned IDX_LO       = 8;
   localparam int unsigned IDX_W        = 5;
   localparam int unsigned BCAST_EN_POS = 0;
   localparam int unsigned CLAMP_POS    = 9;
   localparam int unsigned POWER_POS    = 1;
   localparam int unsigned GLOBAL_POS   = 0;
   // ==========================================================
   // commands
   localparam logic [2:0] CMD_BROADCAST = 3'h3;
   localparam logic [2:0] CMD_CONTROL   = 3'h7;
   // ==========================================================
   // sizes and reset values
   localparam int unsigned NUM_OUT      = 32;
   localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
   localparam logic [IDX_W-1:0]  RST_IDX  = 5'h00;
   localparam logic RST_BCAST_ON  = 1'b0;
   localparam logic RST_CLAMP     = 1'b0;
   localparam logic RST_OPER      = 1'b0; // standby
   localparam logic RST_GLOBAL_EN = 1'b0; // all outputs off
endpackage : xpt_ctrl_pkg
